// ==== design/dsc_pkg.sv ====
// Shared constants and types for the DDR2-style command link and both of its ends
package dsc_pkg;
    // Link widths
    localparam int BANK_W = 3;
    localparam int ROW_W = 15;
    localparam int COL_W = 10;
    localparam int DQ_W = 8;
    localparam int NUM_BANKS = 8;
    // Address bit that carries auto precharge / all-bank precharge
    localparam int AP_BIT = 10;
    // Burst lengths and latency limits
    localparam logic [3:0] BL4 = 4'h4;
    localparam logic [3:0] BL8 = 4'h8;
    localparam logic [2:0] CL_MIN = 3'h3;
    localparam logic [2:0] CL_MAX = 3'h7;
    localparam logic [2:0] AL_MAX = 3'h6;
    // Command codes {cs_n, ras_n, cas_n, we_n}
    localparam logic [3:0] CMD_NOP = 4'h7;
    localparam logic [3:0] CMD_ACT = 4'h3;
    localparam logic [3:0] CMD_RD = 4'h5;
    localparam logic [3:0] CMD_WR = 4'h4;
    localparam logic [3:0] CMD_PRE = 4'h2;
    localparam logic [3:0] CMD_REF = 4'h1;
    // Controller register map (APB byte addresses)
    localparam logic [7:0] REG_CMD = 8'h00;
    localparam logic [7:0] REG_ADDR = 8'h04;
    localparam logic [7:0] REG_WDATA = 8'h08;
    localparam logic [7:0] REG_CFG = 8'h0c;
    localparam logic [7:0] REG_STAT = 8'h10;
    localparam logic [7:0] REG_RDATA = 8'h14;
    // Config field positions
    localparam int CFG_BL8_POS = 0;
    localparam int CFG_CL_POS = 4;
    localparam int CFG_AL_POS = 8;
    localparam int CFG_CKE_POS = 12;
    // Config bit that masks the first beat of each write burst
    localparam int CFG_DM_POS = 13;
    // Command register bit that drops clock enable with a refresh
    localparam int CMD_SREF_POS = 4;
    localparam logic [31:0] CFG_RESET = 32'h0000_1030;
    // Device power states
    typedef enum logic [1:0] {PWR_ON, PWR_PRE_PD, PWR_ACT_PD, PWR_SELF_REF} dsc_pwr_t;
    // Read latency as AL + CL
    function automatic logic [3:0] rd_lat(input logic [2:0] al, input logic [2:0] cl);
        rd_lat = {1'b0, al} + {1'b0, cl};
    endfunction
endpackage

// ==== design/dsc_link_if.sv ====
// Command, address and data link between controller and memory device
`timescale 1ns/1ps
interface dsc_link_if;
    import dsc_pkg::*;
    logic cke;
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [BANK_W-1:0] ba;
    logic [ROW_W-1:0] addr;
    logic [DQ_W-1:0] dq_ctl;
    logic dq_ctl_oe;
    logic [DQ_W-1:0] dq_dev;
    logic dq_dev_oe;
    logic dm;
    // Resolved data bus
    logic [DQ_W-1:0] dq;
    assign dq = dq_dev_oe ? dq_dev : dq_ctl;
    modport ctl (output cke, cs_n, ras_n, cas_n, we_n, ba, addr, dq_ctl, dq_ctl_oe, dm,
                 input dq, dq_dev_oe);
    modport dev (input cke, cs_n, ras_n, cas_n, we_n, ba, addr, dq_ctl, dq_ctl_oe, dm, dq,
                 output dq_dev, dq_dev_oe);
endinterface

// ==== design/dsc_device.sv ====
// Memory device end: command decode, bank state, latency timing, burst data and power states
// Summary of operation
// - bursts of 4 or 8 from start column, A0 ignored
// - CAS latency 3 to 7 accepted
// - additive latency 0 to 6 accepted
// - write data one cycle before read latency
// - eight banks, chosen by bank address
// - controller opens row before read/write (not enforced; device ignores read/write to a closed bank)
// - activate takes bank and row address
// - column from A0-A9, A10 auto precharge
// - one data beat per clock cycle
// - inputs sampled on rising clock edge
// - clock enable low enters power-down state
// - self refresh exit taken on rising clock edge with clock enable high
// - controller keeps clock enable high during access (not enforced; clock enable follows APB writes even mid-burst)
// - power-down ignores all but clock enable
// - self refresh ignores all but clock enable
// - chip select high masks every command
// - controller initialises before normal traffic (no initialisation sequence is issued here)
// - command decoded from strobes with select
// - precharge one bank or all via A10
// - masked write beats are discarded
`timescale 1ns/1ps
module dsc_device import dsc_pkg::*; #(
    parameter int DEPTH = 64,
    parameter logic WIDE_ROW = 1'b1
) (
    input wire logic clock,
    input wire logic arst_n,
    dsc_link_if.dev link,
    input wire logic bl8,
    input wire logic [2:0] cas_lat,
    input wire logic [2:0] add_lat,
    output logic [NUM_BANKS-1:0] bank_open,
    output logic [1:0] pwr_state,
    output logic cfg_err
);
    // Data store, one entry per column pair, two beats per entry
    logic [2*DQ_W-1:0] mem [DEPTH];
    logic [NUM_BANKS-1:0] open_r, open_nxt;
    logic [ROW_W-1:0] row_r [NUM_BANKS];
    logic [ROW_W-1:0] row_nxt [NUM_BANKS];
    dsc_pwr_t pwr_r, pwr_nxt;
    logic [3:0] cmd;
    logic [15:0] rd_pipe_r, rd_pipe_nxt, wr_pipe_r, wr_pipe_nxt;
    logic [COL_W-1:0] col_r, col_nxt;
    logic [BANK_W-1:0] bank_r, bank_nxt;
    logic ap_r, ap_nxt;
    logic [2:0] beat_r, beat_nxt;
    logic rd_act_r, rd_act_nxt, wr_act_r, wr_act_nxt;
    logic [DQ_W-1:0] dq_r, dq_nxt;
    logic oe_r, oe_nxt;
    logic err_r, err_nxt;
    logic [3:0] rl, wl;
    logic [2:0] blen;
    logic [ROW_W-1:0] row_in;
    logic [$clog2(DEPTH)-1:0] widx;
    logic [2*DQ_W-1:0] wword;
    logic wen;

    // Command decode; chip select is part of the code
    always_comb begin
        cmd = {link.cs_n, link.ras_n, link.cas_n, link.we_n};
        if (link.cs_n || pwr_r != PWR_ON) begin
            cmd = CMD_NOP;
        end
        rl = rd_lat(add_lat, cas_lat);
        wl = rl - 4'h1;
        blen = bl8 ? 3'h7 : 3'h3;
        row_in = WIDE_ROW ? link.addr : {1'b0, link.addr[ROW_W-2:0]};
    end

    // Bank, power, and burst next state
    always_comb begin
        open_nxt = open_r;
        row_nxt = row_r;
        pwr_nxt = pwr_r;
        rd_pipe_nxt = {rd_pipe_r[14:0], 1'b0};
        wr_pipe_nxt = {wr_pipe_r[14:0], 1'b0};
        col_nxt = col_r;
        bank_nxt = bank_r;
        ap_nxt = ap_r;
        beat_nxt = beat_r;
        rd_act_nxt = rd_act_r;
        wr_act_nxt = wr_act_r;
        dq_nxt = dq_r;
        oe_nxt = 1'b0;
        wen = 1'b0;
        widx = '0;
        wword = '0;
        // Latency settings outside the accepted ranges are flagged
        err_nxt = (cas_lat < CL_MIN) || (add_lat > AL_MAX);
        case (pwr_r)
            PWR_ON: begin
                if (!link.cke) begin
                    if (open_r != '0) begin
                        pwr_nxt = PWR_ACT_PD;
                    end else if (link.cs_n == 1'b0 && cmd == CMD_REF) begin
                        pwr_nxt = PWR_SELF_REF;
                    end else begin
                        pwr_nxt = PWR_PRE_PD;
                    end
                end
            end
            PWR_PRE_PD, PWR_ACT_PD: begin
                if (link.cke) begin
                    pwr_nxt = PWR_ON;
                end
            end
            PWR_SELF_REF: begin
                if (link.cke) begin
                    pwr_nxt = PWR_ON;
                end
            end
            default: pwr_nxt = PWR_ON;
        endcase
        // Bank commands, eight independent banks
        case (cmd)
            CMD_ACT: begin
                open_nxt[link.ba] = 1'b1;
                row_nxt[link.ba] = row_in;
            end
            CMD_PRE: begin
                if (link.addr[AP_BIT]) begin
                    open_nxt = '0;
                end else begin
                    open_nxt[link.ba] = 1'b0;
                end
            end
            CMD_RD: begin
                if (open_r[link.ba]) begin
                    rd_pipe_nxt[0] = 1'b1;
                    col_nxt = link.addr[COL_W-1:0];
                    bank_nxt = link.ba;
                    ap_nxt = link.addr[AP_BIT];
                end
            end
            CMD_WR: begin
                if (open_r[link.ba]) begin
                    wr_pipe_nxt[0] = 1'b1;
                    col_nxt = link.addr[COL_W-1:0];
                    bank_nxt = link.ba;
                    ap_nxt = link.addr[AP_BIT];
                end
            end
            default: ;
        endcase
        // Burst start after latency
        if (rd_pipe_r[rl-4'h1]) begin
            rd_act_nxt = 1'b1;
            beat_nxt = '0;
        end
        // Write beats are taken in the same cycle the controller drives them on the link
        if (wr_pipe_r[wl]) begin
            wr_act_nxt = 1'b1;
            beat_nxt = '0;
        end
        // Read burst: one beat per cycle, low beat then high on link
        if (rd_act_r) begin
            widx = (col_r[$clog2(DEPTH):1] + beat_r[2:1]);
            dq_nxt = beat_r[0] ? mem[widx][2*DQ_W-1:DQ_W] : mem[widx][DQ_W-1:0];
            oe_nxt = 1'b1;
        end
        // Write burst, masked beats keep old data
        if (wr_act_r) begin
            widx = (col_r[$clog2(DEPTH):1] + beat_r[2:1]);
            wword = mem[widx];
            if (!link.dm) begin
                if (beat_r[0]) begin
                    wword[2*DQ_W-1:DQ_W] = link.dq;
                end else begin
                    wword[DQ_W-1:0] = link.dq;
                end
            end
            wen = 1'b1;
        end
        if (rd_act_r || wr_act_r) begin
            beat_nxt = beat_r + 3'h1;
            if (beat_r == blen) begin
                rd_act_nxt = 1'b0;
                wr_act_nxt = 1'b0;
                if (ap_r) begin
                    open_nxt[bank_r] = 1'b0;
                end
            end
        end
    end

    // Registers
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            open_r <= '0;
            for (int i = 0; i < NUM_BANKS; i++) begin
                row_r[i] <= '0;
            end
            pwr_r <= PWR_ON;
            rd_pipe_r <= '0;
            wr_pipe_r <= '0;
            col_r <= '0;
            bank_r <= '0;
            ap_r <= 1'b0;
            beat_r <= '0;
            rd_act_r <= 1'b0;
            wr_act_r <= 1'b0;
            dq_r <= '0;
            oe_r <= 1'b0;
            err_r <= 1'b0;
        end else begin
            open_r <= open_nxt;
            row_r <= row_nxt;
            pwr_r <= pwr_nxt;
            rd_pipe_r <= rd_pipe_nxt;
            wr_pipe_r <= wr_pipe_nxt;
            col_r <= col_nxt;
            bank_r <= bank_nxt;
            ap_r <= ap_nxt;
            beat_r <= beat_nxt;
            rd_act_r <= rd_act_nxt;
            wr_act_r <= wr_act_nxt;
            dq_r <= dq_nxt;
            oe_r <= oe_nxt;
            err_r <= err_nxt;
        end
    end

    // Storage array write port
    always_ff @(posedge clock) begin
        if (wen) begin
            mem[widx] <= wword;
        end
    end

    assign link.dq_dev = dq_r;
    assign link.dq_dev_oe = oe_r;
    assign bank_open = open_r;
    assign pwr_state = pwr_r;
    assign cfg_err = err_r;
endmodule

// ==== design/dsc_controller.sv ====
// Controller end: APB registers drive single commands and write data onto the link
`timescale 1ns/1ps
module dsc_controller import dsc_pkg::*; (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    dsc_link_if.ctl link,
    output logic bl8,
    output logic [2:0] cas_lat,
    output logic [2:0] add_lat
);
    logic [31:0] cfg_r, cfg_nxt, addr_r, addr_nxt, wdat_r, wdat_nxt, rdat_r, rdat_nxt;
    logic [31:0] prd_r, prd_nxt;
    logic [3:0] cmd_r, cmd_nxt;
    logic [15:0] wpipe_r, wpipe_nxt;
    logic [2:0] beat_r, beat_nxt;
    logic wact_r, wact_nxt, ract_r, ract_nxt;
    logic [DQ_W-1:0] dq_r, dq_nxt;
    logic oe_r, oe_nxt;
    logic dm_r, dm_nxt;
    logic acc, busy;
    logic [3:0] wl;

    // APB access and command issue
    always_comb begin
        acc = psel && penable;
        busy = wact_r || (wpipe_r != '0);
        wl = rd_lat(cfg_r[CFG_AL_POS +: 3], cfg_r[CFG_CL_POS +: 3]) - 4'h1;
        cfg_nxt = cfg_r;
        addr_nxt = addr_r;
        wdat_nxt = wdat_r;
        rdat_nxt = rdat_r;
        cmd_nxt = CMD_NOP;
        wpipe_nxt = {wpipe_r[14:0], 1'b0};
        beat_nxt = beat_r;
        wact_nxt = wact_r;
        ract_nxt = ract_r;
        dq_nxt = dq_r;
        oe_nxt = 1'b0;
        dm_nxt = 1'b0;
        prd_nxt = prd_r;
        if (acc && pwrite) begin
            case (paddr)
                REG_CMD: begin
                    cmd_nxt = pwdata[3:0];
                    if (pwdata[3:0] == CMD_WR) begin
                        wpipe_nxt[0] = 1'b1;
                    end
                    if (pwdata[3:0] == CMD_RD) begin
                        rdat_nxt = '0;
                    end
                    // Refresh with clock enable dropped in the same cycle
                    if (pwdata[3:0] == CMD_REF && pwdata[CMD_SREF_POS]) begin
                        cfg_nxt[CFG_CKE_POS] = 1'b0;
                    end
                end
                REG_ADDR: addr_nxt = pwdata;
                REG_WDATA: wdat_nxt = pwdata;
                REG_CFG: cfg_nxt = pwdata;
                default: ;
            endcase
        end
        // Read data registered in the setup cycle, so it stands in the access cycle
        if (psel && !penable && !pwrite) begin
            case (paddr)
                REG_CMD: prd_nxt = {28'h0, cmd_r};
                REG_ADDR: prd_nxt = addr_r;
                REG_WDATA: prd_nxt = wdat_r;
                REG_CFG: prd_nxt = cfg_r;
                REG_STAT: prd_nxt = {30'h0, ract_r, busy};
                REG_RDATA: prd_nxt = rdat_r;
                default: prd_nxt = '0;
            endcase
        end
        // Write data leaves one cycle before read latency
        if (wpipe_r[wl]) begin
            wact_nxt = 1'b1;
            beat_nxt = '0;
        end
        if (wact_r) begin
            dq_nxt = wdat_r[beat_r[1:0]*8 +: 8];
            oe_nxt = 1'b1;
            dm_nxt = cfg_r[CFG_DM_POS] && (beat_r == 3'h0);
            beat_nxt = beat_r + 3'h1;
            if (beat_r == (cfg_r[CFG_BL8_POS] ? 3'h7 : 3'h3)) begin
                wact_nxt = 1'b0;
            end
        end
        // Capture read beats, shifting each into the low byte
        ract_nxt = link.dq_dev_oe;
        if (link.dq_dev_oe) begin
            rdat_nxt = {rdat_r[23:0], link.dq};
        end
    end

    // Registers; the device runs on the same clock, so its data is used directly
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            cfg_r <= CFG_RESET;
            addr_r <= '0;
            wdat_r <= '0;
            rdat_r <= '0;
            prd_r <= '0;
            cmd_r <= CMD_NOP;
            wpipe_r <= '0;
            beat_r <= '0;
            wact_r <= 1'b0;
            ract_r <= 1'b0;
            dq_r <= '0;
            oe_r <= 1'b0;
            dm_r <= 1'b0;
        end else begin
            cfg_r <= cfg_nxt;
            addr_r <= addr_nxt;
            wdat_r <= wdat_nxt;
            rdat_r <= rdat_nxt;
            prd_r <= prd_nxt;
            cmd_r <= cmd_nxt;
            wpipe_r <= wpipe_nxt;
            beat_r <= beat_nxt;
            wact_r <= wact_nxt;
            ract_r <= ract_nxt;
            dq_r <= dq_nxt;
            oe_r <= oe_nxt;
            dm_r <= dm_nxt;
        end
    end

    // Link outputs and prdata from flip-flops; pready and pslverr tied to constants
    assign link.cke = cfg_r[CFG_CKE_POS];
    assign {link.cs_n, link.ras_n, link.cas_n, link.we_n} = cmd_r;
    assign link.ba = addr_r[ROW_W +: BANK_W];
    assign link.addr = addr_r[ROW_W-1:0];
    assign link.dq_ctl = dq_r;
    assign link.dq_ctl_oe = oe_r;
    assign link.dm = dm_r;
    assign prdata = prd_r;
    assign pready = 1'b1;
    assign pslverr = 1'b0;
    assign bl8 = cfg_r[CFG_BL8_POS];
    assign cas_lat = cfg_r[CFG_CL_POS +: 3];
    assign add_lat = cfg_r[CFG_AL_POS +: 3];
endmodule

// ==== verif/dsc_link_assertions.sv ====
// Concurrent checks on the command link joining controller and device
`timescale 1ns/1ps
module dsc_link_assertions import dsc_pkg::*; (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic cke,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic [BANK_W-1:0] ba,
    input wire logic [ROW_W-1:0] addr,
    input wire logic dq_ctl_oe,
    input wire logic dq_dev_oe,
    input wire logic bl8,
    input wire logic [2:0] cas_lat,
    input wire logic [2:0] add_lat,
    input wire logic [NUM_BANKS-1:0] bank_open,
    input wire logic [1:0] pwr_state
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);
    logic [3:0] cmd;
    logic [3:0] lat;
    logic rd_go;
    logic wr_go;
    logic [15:0] rd_hist_r;
    logic [15:0] rd_hist_nxt;
    logic [15:0] wr_hist_r;
    logic [15:0] wr_hist_nxt;
    // Command code, latency in force, reads the device must act on, and every write command code
    assign cmd = {cs_n, ras_n, cas_n, we_n};
    assign lat = {1'b0, add_lat} + {1'b0, cas_lat};
    assign rd_go = cmd == CMD_RD && cke && pwr_state == 2'h0 && bank_open[ba];
    assign wr_go = cmd == CMD_WR;
    // Age history of column commands, one bit per cycle
    always_comb begin
        rd_hist_nxt = {rd_hist_r[14:0], rd_go};
        wr_hist_nxt = {wr_hist_r[14:0], wr_go};
    end
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            rd_hist_r <= 16'h0000;
            wr_hist_r <= 16'h0000;
        end else begin
            rd_hist_r <= rd_hist_nxt;
            wr_hist_r <= wr_hist_nxt;
        end
    end
    property p_act_opens;
        cmd == CMD_ACT && cke && pwr_state == 2'h0 |=> bank_open[$past(ba)];
    endproperty
    a_act_opens: assert property (p_act_opens) else $error("activate left bank closed");
    property p_pre_one;
        cmd == CMD_PRE && cke && pwr_state == 2'h0 && !addr[AP_BIT]
            |=> bank_open == ($past(bank_open) & ~(8'h01 << $past(ba)));
    endproperty
    a_pre_one: assert property (p_pre_one) else $error("single precharge wrong banks");
    property p_pre_all;
        cmd == CMD_PRE && cke && pwr_state == 2'h0 && addr[AP_BIT] |=> bank_open == 8'h00;
    endproperty
    a_pre_all: assert property (p_pre_all) else $error("precharge all left a bank open");
    property p_rd_lat;
        $rose(dq_dev_oe) |-> rd_hist_r[lat] || rd_hist_r[lat + 4'h1];
    endproperty
    a_rd_lat: assert property (p_rd_lat) else $error("read data at wrong latency");
    property p_wr_lat;
        $rose(dq_ctl_oe) |-> wr_hist_r[lat - 4'h1] || wr_hist_r[lat];
    endproperty
    a_wr_lat: assert property (p_wr_lat) else $error("write data at wrong latency");
    property p_burst8;
        $rose(dq_dev_oe) && bl8 |-> dq_dev_oe [*8] ##1 !dq_dev_oe;
    endproperty
    a_burst8: assert property (p_burst8) else $error("read burst not eight beats");
    property p_cke_access;
        dq_dev_oe || dq_ctl_oe |-> cke;
    endproperty
    a_cke_access: assert property (p_cke_access) else $error("clock enable low in access");
    property p_ppd;
        pwr_state == 2'h0 && !cke && bank_open == 8'h00 && cmd != CMD_REF |=> pwr_state == 2'h1;
    endproperty
    a_ppd: assert property (p_ppd) else $error("no precharge power-down");
    property p_apd;
        pwr_state == 2'h0 && !cke && bank_open != 8'h00 |=> pwr_state == 2'h2;
    endproperty
    a_apd: assert property (p_apd) else $error("no active power-down");
    property p_sref;
        pwr_state == 2'h0 && !cke && bank_open == 8'h00 && cmd == CMD_REF |=> pwr_state == 2'h3;
    endproperty
    a_sref: assert property (p_sref) else $error("no self refresh entry");
    property p_pd_ignore;
        pwr_state != 2'h0 && !cke |=> $stable(bank_open);
    endproperty
    a_pd_ignore: assert property (p_pd_ignore) else $error("command taken in power-down");
endmodule

// ==== verif/ddr2_sdram_command_access_tb.sv ====
// Testbench: APB-driven controller joined to the device over the command link
`timescale 1ns/1ps
module ddr2_sdram_command_access_tb import dsc_pkg::*;;
    logic clock;
    logic arst_n;
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic bl8;
    logic [2:0] cas_lat;
    logic [2:0] add_lat;
    logic [NUM_BANKS-1:0] bank_open;
    logic [1:0] pwr_state;
    logic cfg_err;
    int err_total = 0;
    int n_compared = 0;
    logic [7:0] rq[$];
    logic [7:0] wq[$];
    dsc_link_if link();
    dsc_controller i_dsc_controller (.clock, .arst_n, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .link(link), .bl8, .cas_lat, .add_lat);
    dsc_device i_dsc_device (.clock, .arst_n, .link(link), .bl8, .cas_lat, .add_lat,
        .bank_open, .pwr_state, .cfg_err);
    dsc_link_assertions i_dsc_link_assertions (.clock, .arst_n, .cke(link.cke),
        .cs_n(link.cs_n), .ras_n(link.ras_n), .cas_n(link.cas_n), .we_n(link.we_n),
        .ba(link.ba), .addr(link.addr), .dq_ctl_oe(link.dq_ctl_oe),
        .dq_dev_oe(link.dq_dev_oe), .bl8, .cas_lat, .add_lat, .bank_open, .pwr_state);
    // Clock at 250 MHz
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    // Capture data beats on the resolved bus, per driving end
    always @(posedge clock) begin
        if (link.dq_dev_oe === 1'b1) rq.push_back(link.dq);
        if (link.dq_ctl_oe === 1'b1) wq.push_back(link.dq);
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        n_compared++;
        if (got !== exp) begin
            $display("mismatch at %0t: %s got %h expected %h", $time, msg, got, exp);
            err_total++;
        end
    endtask
    task automatic finish_test;
        $display("compared %0d, mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // One APB transfer; read data is taken at the edge that completes the access
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1) begin
            @(posedge clock);
        end
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        apb(1'b1, a, d, q);
    endtask
    // Put one command with bank and address on the link
    task automatic cmd(input logic [3:0] c, input logic [2:0] b, input logic [14:0] a);
        wr(REG_ADDR, {14'h0, b, a});
        wr(REG_CMD, {28'h0, c});
        repeat (2) @(posedge clock);
    endtask
    function automatic logic [31:0] cfgw(input logic b, input logic [2:0] cl,
                                         input logic [2:0] al, input logic ck);
        cfgw = {19'h0, ck, 1'b0, al, 1'b0, cl, 3'h0, b};
    endfunction
    // Main sequence
    initial begin
        logic [31:0] d;
        logic [31:0] wd;
        int bl;
        arst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (8) @(posedge clock);
        arst_n <= 1'b1;
        @(posedge clock);
        apb(1'b0, REG_CFG, 32'h0, d);
        chk(d, CFG_RESET, "cfg reset value");
        apb(1'b0, 8'h20, 32'h0, d);
        chk(d, 32'h0, "unmapped read");
        chk(pslverr, 32'h0, "no slave error");
        chk(bank_open, 32'h0, "banks idle after reset");
        rq.delete();
        cmd(CMD_RD, 3'h0, 15'h0000);
        repeat (20) @(posedge clock);
        chk(rq.size(), 32'h0, "read to closed bank");
        cmd(CMD_ACT, 3'h5, 15'h4abc);
        cmd(CMD_ACT, 3'h2, 15'h7fff);
        chk(bank_open, 32'h24, "two banks opened");
        cmd(CMD_ACT | 4'h8, 3'h0, 15'h0001);
        chk(bank_open, 32'h24, "deselected activate");
        for (int i = 0; i < 7; i++) begin
            bl = i[0] ? 8 : 4;
            wd = 32'h03020100 + {4{8'(i * 16)}};
            wr(REG_CFG, cfgw(i[0], 3'(3 + i % 5), 3'(i), 1'b1));
            wr(REG_WDATA, wd);
            wq.delete();
            rq.delete();
            cmd(CMD_WR, 3'h5, 15'h0008);
            for (int k = 0; k < 80 && wq.size() < bl; k++) @(posedge clock);
            repeat (4) @(posedge clock);
            cmd(CMD_RD, 3'h5, 15'h0008);
            for (int k = 0; k < 80 && rq.size() < bl; k++) @(posedge clock);
            repeat (4) @(posedge clock);
            chk(cfg_err, 32'h0, "legal latency refused");
            chk(wq.size(), bl, "write beat count");
            chk(rq.size(), bl, "read beat count");
            for (int j = 0; j < bl && j < rq.size() && j < wq.size(); j++) begin
                chk(wq[j], wd[8 * (j % 4) +: 8], "write beat");
                chk(rq[j], wd[8 * (j % 4) +: 8], "read beat");
            end
        end
        // Masked first beat keeps the byte left by the last loop pass
        wr(REG_CFG, cfgw(1'b0, 3'h3, 3'h0, 1'b1) | (32'h1 << CFG_DM_POS));
        wr(REG_WDATA, 32'ha5a4a3a2);
        cmd(CMD_WR, 3'h5, 15'h0008);
        repeat (12) @(posedge clock);
        rq.delete();
        cmd(CMD_RD, 3'h5, 15'h0008);
        repeat (12) @(posedge clock);
        chk(rq.size(), 32'h4, "masked burst length");
        chk({rq[3], rq[2], rq[1], rq[0]}, 32'ha5a4a360, "masked write beat");
        apb(1'b0, REG_RDATA, 32'h0, d);
        chk(d, 32'h60a3a4a5, "read data register");
        wr(REG_CFG, cfgw(1'b0, 3'h2, 3'h0, 1'b1));
        repeat (3) @(posedge clock);
        chk(cfg_err, 32'h1, "cas latency two");
        wr(REG_CFG, cfgw(1'b0, 3'h3, 3'h7, 1'b1));
        repeat (3) @(posedge clock);
        chk(cfg_err, 32'h1, "additive latency seven");
        wr(REG_CFG, cfgw(1'b0, 3'h3, 3'h0, 1'b1));
        cmd(CMD_PRE, 3'h2, 15'h0000);
        chk(bank_open, 32'h20, "single bank precharge");
        cmd(CMD_ACT, 3'h2, 15'h0003);
        cmd(CMD_PRE, 3'h0, 15'h0400);
        chk(bank_open, 32'h0, "precharge all");
        wr(REG_CFG, cfgw(1'b0, 3'h3, 3'h0, 1'b0));
        repeat (3) @(posedge clock);
        chk(pwr_state, 32'h1, "precharge power-down");
        cmd(CMD_ACT, 3'h1, 15'h0000);
        chk(bank_open, 32'h0, "activate in power-down");
        wr(REG_CFG, cfgw(1'b0, 3'h3, 3'h0, 1'b1));
        repeat (3) @(posedge clock);
        chk(pwr_state, 32'h0, "power-down exit");
        cmd(CMD_ACT, 3'h1, 15'h0000);
        wr(REG_CFG, cfgw(1'b0, 3'h3, 3'h0, 1'b0));
        repeat (3) @(posedge clock);
        chk(pwr_state, 32'h2, "active power-down");
        wr(REG_CFG, cfgw(1'b0, 3'h3, 3'h0, 1'b1));
        repeat (3) @(posedge clock);
        chk(bank_open, 32'h02, "row kept in power-down");
        cmd(CMD_PRE, 3'h0, 15'h0400);
        wr(REG_CMD, (32'h1 << CMD_SREF_POS) | {28'h0, CMD_REF});
        repeat (3) @(posedge clock);
        chk(pwr_state, 32'h3, "self refresh entry");
        cmd(CMD_ACT, 3'h1, 15'h0000);
        chk(bank_open, 32'h0, "activate in self refresh");
        wr(REG_CFG, cfgw(1'b0, 3'h3, 3'h0, 1'b1));
        repeat (3) @(posedge clock);
        chk(pwr_state, 32'h0, "self refresh exit");
        finish_test();
    end
    // Watchdog well beyond the expected run length
    initial begin
        repeat (30000) @(posedge clock);
        err_total++;
        finish_test();
    end
endmodule
